/* File: exec_defs.vh */
// constants for the bit, flag and transfer execution block
// assumes one 10 MHz core clock and a classic wishbone slave port
`ifndef EXEC_DEFS_VH
`define EXEC_DEFS_VH

// ----------------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ----------------------------------------------------------------------
`define ADR_CMD 12'h000
`define ADR_OPND 12'h004
`define ADR_FLAGS 12'h008
`define ADR_STATE 12'h00C
`define ADR_SP 12'h010
`define RF_WIN 5'h02
`define IO_WIN 4'h2
`define PM_WIN 2'h1

// ----------------------------------------------------------------------
// operand fields
// ----------------------------------------------------------------------
`define OPND_REG_MSB 4
`define OPND_BIT_LSB 5
`define OPND_BIT_MSB 7
`define OPND_IO_LSB 8
`define OPND_IO_MSB 13
`define OPND_W 14

// ----------------------------------------------------------------------
// status flag bit positions and reset values
// ----------------------------------------------------------------------
`define FLG_C 0
`define FLG_Z 1
`define FLG_N 2
`define FLG_V 3
`define FLG_S 4
`define FLG_H 5
`define FLG_T 6
`define FLG_I 7
`define FLAGS_RST 8'h00
`define SP_RST 8'hFF
`define Z_LO_REG 5'h1E
`define Z_HI_REG 5'h1F

// ----------------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------------
`define OP_NOP 5'h00
`define OP_PML 5'h01
`define OP_PML_INC 5'h02
`define OP_PUSH 5'h03
`define OP_POP 5'h04
`define OP_IN 5'h05
`define OP_OUT 5'h06
`define OP_IOSET 5'h07
`define OP_IOCLR 5'h08
`define OP_LSL 5'h09
`define OP_LSR 5'h0A
`define OP_ROLC 5'h0B
`define OP_RORC 5'h0C
`define OP_ASR 5'h0D
`define OP_SWAP 5'h0E
`define OP_FSET 5'h0F
`define OP_FCLR 5'h10
`define OP_TSTORE 5'h11
`define OP_TLOAD 5'h12
`define OP_SLEEP 5'h13
`define OP_WDOG 5'h14
`define OP_BREAK 5'h15

// ----------------------------------------------------------------------
// shift unit selects and cycle counts
// ----------------------------------------------------------------------
`define SH_LSL 3'h0
`define SH_LSR 3'h1
`define SH_ROL 3'h2
`define SH_ROR 3'h3
`define SH_ASR 3'h4
`define SH_SWAP 3'h5
`define CYC_PML 2'h3
`define CYC_TWO 2'h2
`define CYC_ONE 2'h1

`endif

/* File: shift_flag_unit.v */
// shift, rotate and nibble swap of one byte with the resulting flags
// assumes pure combinational use by the execution block
`timescale 1ns/10ps
`include "exec_defs.vh"

module shift_flag_unit (
    input wire [2:0] sel,     // shift kind
    input wire [7:0] val,     // operand byte
    input wire c_in,          // carry before the operation
    output reg [7:0] res,     // result byte
    output reg c_out,         // new carry
    output wire z_out,        // result is zero
    output wire n_out,        // result bit 7
    output wire v_out         // negative xor carry
);
    always @* begin
        res = val;
        c_out = c_in;
        case (sel)
            `SH_LSL: begin
                res = {val[6:0], 1'b0};
                c_out = val[7];
            end
            `SH_LSR: begin
                res = {1'b0, val[7:1]};
                c_out = val[0];
            end
            `SH_ROL: begin
                res = {val[6:0], c_in};
                c_out = val[7];
            end
            `SH_ROR: begin
                res = {c_in, val[7:1]};
                c_out = val[0];
            end
            `SH_ASR: begin
                res = {val[7], val[7:1]};
                c_out = val[0];
            end
            `SH_SWAP: begin
                res = {val[3:0], val[7:4]};
            end
            default: begin
                res = val;
            end
        endcase
    end

    assign z_out = (res == 8'h00);
    assign n_out = res[7];
    assign v_out = res[7] ^ c_out;
endmodule

/* File: bit_flag_transfer_exec.v */
// What this block does
// - program load copies byte at Z into register, Z plus one only for OP_PML_INC, 3 cycles.
// - push writes source register onto stack in 2 cycles, flags kept.
// - pop loads destination register from stack in 2 cycles, flags kept.
// - io bit set forces bit b of io register to one, 2 cycles.
// - io bit clear forces bit b of io register to zero, 2 cycles.
// - rotate left through carry, old bit 7 to carry, ZCNV, 1 cycle.
// - rotate right through carry, old bit 0 to carry, ZCNV, 1 cycle.
// - bit store copies register bit b into transfer flag only, 1 cycle.
// - bit load copies transfer flag into register bit b, 1 cycle.
// - overflow set and clear drive only overflow flag, 1 cycle.
// - half carry set and clear drive only half carry flag, 1 cycle.
// - sign set and clear drive only sign flag, 1 cycle.
// - sleep issues in 1 cycle, flags kept, raises sleep request.
// - watchdog restart in 1 cycle, flags kept, raises restart request.
// - debug break keeps all flags, raises debug break request.
//
// assumes a classic wishbone master on sys_clk; one operation at a time
//
// The Wishbone register port and the register addresses were decided locally.
`timescale 1ns/10ps
`include "exec_defs.vh"

module bit_flag_transfer_exec (
    input wire sys_clk,            // core clock
    input wire reset_n,            // async reset, active low
    input wire wb_cyc_i,           // bus cycle
    input wire wb_stb_i,           // bus strobe
    input wire wb_we_i,            // write enable
    input wire [11:0] wb_adr_i,    // byte address
    input wire [3:0] wb_sel_i,     // byte lanes
    input wire [31:0] wb_dat_i,    // write data
    output reg [31:0] wb_dat_o,    // read data
    output reg wb_ack_o,           // acknowledge
    output reg sleep_req,          // pulse to sleep logic
    output reg wdog_restart,       // pulse to watchdog
    output reg break_req           // pulse to debug logic
);
    // ------------------------------------------------------------------
    // state and storage
    // ------------------------------------------------------------------
    localparam ST_IDLE = 2'b01;
    localparam ST_EXEC = 2'b10;

    reg [1:0] st_q;
    reg [1:0] cnt_q;
    reg [4:0] op_q;
    reg [4:0] last_op_q;
    reg [`OPND_W-1:0] opnd_q;
    reg [7:0] flags_q;
    reg [7:0] sp_q;

    reg [7:0] rf [0:31];
    reg [7:0] io [0:63];
    reg [7:0] pmem [0:255];
    reg [7:0] stk [0:255];

    // ------------------------------------------------------------------
    // operand decode
    // ------------------------------------------------------------------
    wire [4:0] ridx = opnd_q[`OPND_REG_MSB:0];
    wire [2:0] bsel = opnd_q[`OPND_BIT_MSB:`OPND_BIT_LSB];
    wire [5:0] ioa = opnd_q[`OPND_IO_MSB:`OPND_IO_LSB];
    wire [7:0] rval = rf[ridx];
    wire [7:0] iov = io[ioa];
    wire [15:0] zptr = {rf[`Z_HI_REG], rf[`Z_LO_REG]};
    wire [15:0] zinc = zptr + 16'h0001;
    wire [7:0] bmask = 8'h01 << bsel;
    wire [7:0] sp_inc = sp_q + 8'h01;
    wire [7:0] sp_dec = sp_q - 8'h01;
    wire busy = st_q[1];
    wire fin = st_q[1] && (cnt_q == 2'h1);

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr_ok = req && wb_we_i && wb_sel_i[0] && !busy;
    wire in_rf = (wb_adr_i[11:7] == `RF_WIN);
    wire in_io = (wb_adr_i[11:8] == `IO_WIN);
    wire in_pm = (wb_adr_i[11:10] == `PM_WIN);
    wire [7:0] wbyte = wb_dat_i[7:0];
    wire start = wr_ok && (wb_adr_i == `ADR_CMD);

    // ------------------------------------------------------------------
    // shift unit
    // ------------------------------------------------------------------
    reg [2:0] sh_sel;
    wire [7:0] sh_res;
    wire sh_c;
    wire sh_z;
    wire sh_n;
    wire sh_v;

    always @* begin
        case (op_q)
            `OP_LSR: sh_sel = `SH_LSR;
            `OP_ROLC: sh_sel = `SH_ROL;
            `OP_RORC: sh_sel = `SH_ROR;
            `OP_ASR: sh_sel = `SH_ASR;
            `OP_SWAP: sh_sel = `SH_SWAP;
            default: sh_sel = `SH_LSL;
        endcase
    end

    shift_flag_unit shift_flag_unit_inst (
        .sel(sh_sel),
        .val(rval),
        .c_in(flags_q[`FLG_C]),
        .res(sh_res),
        .c_out(sh_c),
        .z_out(sh_z),
        .n_out(sh_n),
        .v_out(sh_v)
    );

    // ------------------------------------------------------------------
    // cycle count of a new operation
    // ------------------------------------------------------------------
    reg [1:0] ncyc;

    always @* begin
        case (wb_dat_i[4:0])
            `OP_PML, `OP_PML_INC: ncyc = `CYC_PML;
            `OP_PUSH, `OP_POP, `OP_IOSET, `OP_IOCLR: ncyc = `CYC_TWO;
            default: ncyc = `CYC_ONE;
        endcase
    end

    // ------------------------------------------------------------------
    // write ports of the storage arrays
    // ------------------------------------------------------------------
    reg rf_we;
    reg [4:0] rf_wa;
    reg [7:0] rf_wd;
    reg z_we;
    reg io_we;
    reg [5:0] io_wa;
    reg [7:0] io_wd;
    reg stk_we;
    reg pm_we;

    always @* begin
        rf_we = 1'b0;
        rf_wa = ridx;
        rf_wd = 8'h00;
        z_we = 1'b0;
        io_we = 1'b0;
        io_wa = ioa;
        io_wd = 8'h00;
        stk_we = 1'b0;
        pm_we = 1'b0;
        if (wr_ok) begin
            rf_we = in_rf;
            rf_wa = wb_adr_i[6:2];
            rf_wd = wbyte;
            io_we = in_io;
            io_wa = wb_adr_i[7:2];
            io_wd = wbyte;
            pm_we = in_pm;
        end else if (fin) begin
            case (op_q)
                `OP_PML, `OP_PML_INC: begin
                    rf_we = 1'b1;
                    rf_wd = pmem[zptr[7:0]];
                    z_we = (op_q == `OP_PML_INC);
                end
                `OP_PUSH: stk_we = 1'b1;
                `OP_POP: begin
                    rf_we = 1'b1;
                    rf_wd = stk[sp_inc];
                end
                `OP_IN: begin
                    rf_we = 1'b1;
                    rf_wd = iov;
                end
                `OP_OUT: begin
                    io_we = 1'b1;
                    io_wd = rval;
                end
                `OP_IOSET: begin
                    io_we = 1'b1;
                    io_wd = iov | bmask;
                end
                `OP_IOCLR: begin
                    io_we = 1'b1;
                    io_wd = iov & ~bmask;
                end
                `OP_LSL, `OP_LSR, `OP_ROLC, `OP_RORC, `OP_ASR,
                `OP_SWAP: begin
                    rf_we = 1'b1;
                    rf_wd = sh_res;
                end
                `OP_TLOAD: begin
                    rf_we = 1'b1;
                    rf_wd = flags_q[`FLG_T] ? (rval | bmask)
                                            : (rval & ~bmask);
                end
                default: rf_we = 1'b0;
            endcase
        end
    end

    always @(posedge sys_clk) begin
        if (rf_we)
            rf[rf_wa] <= rf_wd;
        if (z_we) begin
            rf[`Z_LO_REG] <= zinc[7:0];
            rf[`Z_HI_REG] <= zinc[15:8];
        end
        if (io_we)
            io[io_wa] <= io_wd;
        if (stk_we)
            stk[sp_q] <= rval;
        if (pm_we)
            pmem[wb_adr_i[9:2]] <= wbyte;
    end

    // ------------------------------------------------------------------
    // sequencer, flags and stack pointer
    // ------------------------------------------------------------------
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= ST_IDLE;
            cnt_q <= 2'h0;
            op_q <= `OP_NOP;
            last_op_q <= `OP_NOP;
            opnd_q <= {`OPND_W{1'b0}};
            flags_q <= `FLAGS_RST;
            sp_q <= `SP_RST;
            sleep_req <= 1'b0;
            wdog_restart <= 1'b0;
            break_req <= 1'b0;
        end else begin
            sleep_req <= 1'b0;
            wdog_restart <= 1'b0;
            break_req <= 1'b0;
            if (wr_ok && wb_adr_i == `ADR_OPND) begin
                opnd_q[7:0] <= wbyte;
                if (wb_sel_i[1])
                    opnd_q[`OPND_W-1:8] <= wb_dat_i[`OPND_W-1:8];
            end
            if (wr_ok && wb_adr_i == `ADR_FLAGS)
                flags_q <= wbyte;
            if (wr_ok && wb_adr_i == `ADR_SP)
                sp_q <= wbyte;
            case (st_q)
                ST_IDLE: begin
                    if (start) begin
                        op_q <= wb_dat_i[4:0];
                        cnt_q <= ncyc;
                        st_q <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    cnt_q <= cnt_q - 2'h1;
                    if (fin) begin
                        st_q <= ST_IDLE;
                        last_op_q <= op_q;
                        case (op_q)
                            `OP_PUSH: sp_q <= sp_dec;
                            `OP_POP: sp_q <= sp_inc;
                            `OP_LSL, `OP_LSR, `OP_ROLC, `OP_RORC,
                            `OP_ASR: begin
                                flags_q[`FLG_C] <= sh_c;
                                flags_q[`FLG_Z] <= sh_z;
                                flags_q[`FLG_N] <= sh_n;
                                flags_q[`FLG_V] <= sh_v;
                            end
                            `OP_FSET: flags_q[bsel] <= 1'b1;
                            `OP_FCLR: flags_q[bsel] <= 1'b0;
                            `OP_TSTORE: flags_q[`FLG_T] <= rval[bsel];
                            `OP_SLEEP: sleep_req <= 1'b1;
                            `OP_WDOG: wdog_restart <= 1'b1;
                            `OP_BREAK: break_req <= 1'b1;
                            default: sp_q <= sp_q;
                        endcase
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // read data and acknowledge
    // ------------------------------------------------------------------
    reg [31:0] rd_mux;

    always @* begin
        rd_mux = 32'h0000_0000;
        if (in_rf)
            rd_mux[7:0] = rf[wb_adr_i[6:2]];
        else if (in_io)
            rd_mux[7:0] = io[wb_adr_i[7:2]];
        else if (in_pm)
            rd_mux[7:0] = pmem[wb_adr_i[9:2]];
        else begin
            case (wb_adr_i)
                `ADR_CMD: rd_mux[4:0] = op_q;
                `ADR_OPND: rd_mux[`OPND_W-1:0] = opnd_q;
                `ADR_FLAGS: rd_mux[7:0] = flags_q;
                `ADR_STATE: rd_mux[12:0] = {last_op_q, 7'h00, busy};
                `ADR_SP: rd_mux[7:0] = sp_q;
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            if (req && !wb_we_i)
                wb_dat_o <= rd_mux;
        end
    end
endmodule

/* File: exec_checker_assertions.sv */
// checker on the execution block's bus answer, busy flag and pulses
// assumes binding to the ports of the block's top module
`timescale 1ns/10ps
`include "exec_defs.vh"

module exec_checker (
    input wire sys_clk,          // core clock
    input wire reset_n,          // async reset, active low
    input wire wb_cyc_i,         // bus cycle
    input wire wb_stb_i,         // bus strobe
    input wire wb_we_i,          // write enable
    input wire [11:0] wb_adr_i,  // byte address
    input wire [3:0] wb_sel_i,   // byte lanes
    input wire [31:0] wb_dat_i,  // write data
    input wire [31:0] wb_dat_o,  // read data
    input wire wb_ack_o,         // acknowledge
    input wire sleep_req,        // sleep pulse
    input wire wdog_restart,     // watchdog pulse
    input wire break_req         // debug pulse
);
    logic [1:0] left_q;
    logic [1:0] len;
    logic busy_q;
    logic st_q;
    logic narrow_q;
    logic take;
    logic go;
    logic go_slp;
    logic [11:0] adr;
    assign adr = {wb_adr_i[11:2], 2'b00};
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign go = take && wb_we_i && wb_sel_i[0] && left_q == 2'h0
        && adr == `ADR_CMD;
    assign go_slp = go && wb_dat_i[4:0] == `OP_SLEEP;
    always @* begin
        case (wb_dat_i[4:0])
            `OP_PML, `OP_PML_INC: len = `CYC_PML;
            `OP_PUSH, `OP_POP, `OP_IOSET, `OP_IOCLR: len = `CYC_TWO;
            default: len = `CYC_ONE;
        endcase
    end
    // cycles left of the running op, as the bus should see it
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            left_q <= 2'h0;
            busy_q <= 1'b0;
            st_q <= 1'b0;
            narrow_q <= 1'b0;
        end else begin
            left_q <= go ? len : left_q - {1'b0, left_q != 2'h0};
            if (take) begin
                busy_q <= left_q != 2'h0;
                st_q <= adr == `ADR_STATE && !wb_we_i;
                narrow_q <= (adr == `ADR_FLAGS || adr == `ADR_SP) && !wb_we_i;
            end
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    sequence one_pulse(sig);
        !sig ##1 sig ##1 !sig;
    endsequence
    property op_pulse(op, sig);
        go && wb_dat_i[4:0] == op |=> one_pulse(sig);
    endproperty
    AST_ACK_AFTER_TAKE: assert property (take |=> wb_ack_o) // bus answer
        else $error("ack missing after request");
    AST_ACK_SINGLE: assert property (wb_ack_o |=> !wb_ack_o) // bus answer
        else $error("ack longer than one cycle");
    AST_BUSY_SEEN: assert property
        (wb_ack_o && st_q |-> wb_dat_o[0] == busy_q)
        else $error("busy bit disagrees with op length");
    AST_NARROW_READ: assert property
        (wb_ack_o && narrow_q |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper bits of byte register not zero");
    AST_SLEEP_PULSE: assert property (op_pulse(`OP_SLEEP, sleep_req))
        else $error("sleep pulse wrong");
    AST_WDOG_PULSE: assert property (op_pulse(`OP_WDOG, wdog_restart))
        else $error("watchdog pulse wrong");
    AST_BREAK_PULSE: assert property (op_pulse(`OP_BREAK, break_req))
        else $error("break pulse wrong");
    AST_SLEEP_CAUSE: assert property (sleep_req |-> $past(go_slp, 2))
        else $error("sleep pulse without sleep op");
    AST_PULSE_ALONE: assert property
        ($onehot0({sleep_req, wdog_restart, break_req}))
        else $error("two request pulses at once");
endmodule

bind bit_flag_transfer_exec exec_checker exec_checker_inst (
    .sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sleep_req(sleep_req),
    .wdog_restart(wdog_restart), .break_req(break_req));

/* File: bit_flag_transfer_exec_tb.sv */
// self-checking bench for the execution block
// assumes the block alone on one clock, driven over wishbone
`timescale 1ns/10ps
`include "exec_defs.vh"

module bit_flag_transfer_exec_tb;
    logic sys_clk;
    logic reset_n;
    logic wb_cyc_i;
    logic wb_stb_i;
    logic wb_we_i;
    logic [11:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i;
    wire [31:0] wb_dat_o;
    wire wb_ack_o;
    wire sleep_req;
    wire wdog_restart;
    wire break_req;
    int error_cnt = 0;
    int samples_checked = 0;
    int pulse_n [3];

    bit_flag_transfer_exec bit_flag_transfer_exec_inst (
        .sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .sleep_req(sleep_req),
        .wdog_restart(wdog_restart), .break_req(break_req));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        pulse_n[0] += (sleep_req === 1'b1);
        pulse_n[1] += (wdog_restart === 1'b1);
        pulse_n[2] += (break_req === 1'b1);
    end

    // ----------------------------------------------------------------
    // bus and compare helpers
    // ----------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t %s got %h want %h", $time, what, seen, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, input logic [3:0] s,
                        output logic [31:0] r);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        for (n = 0; n < 8; n++) begin
            @(posedge sys_clk);
            if (wb_ack_o === 1'b1) break;
        end
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge sys_clk);
        if (n == 8) begin
            error_cnt++;
            $display("[ERR] %0t no ack", $time);
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, 4'hF, r);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp,
                       input string what);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, 4'hF, r);
        check(r, exp, what);
    endtask
    function automatic logic [11:0] win(input logic [11:0] b,
                                        input logic [7:0] i);
        return b + {2'b00, i, 2'b00};
    endfunction
    task automatic run_op(input logic [4:0] op, input logic [13:0] opnd);
        logic [31:0] r;
        int n;
        wr(`ADR_OPND, {18'h0, opnd});
        wr(`ADR_CMD, {27'h0, op});
        r = 32'h1;
        for (n = 0; n < 10 && r[0] !== 1'b0; n++)
            xfer(1'b0, `ADR_STATE, 32'h0, 4'hF, r);
        if (r[0] !== 1'b0) begin
            error_cnt++;
            $display("[ERR] %0t op stuck busy", $time);
            tally_and_finish();
        end
    endtask
    function automatic logic [15:0] shift_ref(input logic [4:0] op,
                                              input logic [7:0] v,
                                              input logic [7:0] f);
        logic [8:0] cr;
        logic [7:0] nf;
        case (op)
            `OP_LSL: cr = {v, 1'b0};
            `OP_LSR: cr = {v[0], 1'b0, v[7:1]};
            `OP_ROLC: cr = {v, f[0]};
            `OP_RORC: cr = {v[0], f[0], v[7:1]};
            `OP_ASR: cr = {v[0], v[7], v[7:1]};
            default: return {f, v[3:0], v[7:4]};
        endcase
        nf = f;
        nf[`FLG_C] = cr[8];
        nf[`FLG_Z] = cr[7:0] == 8'h00;
        nf[`FLG_N] = cr[7];
        nf[`FLG_V] = cr[7] ^ cr[8];
        return {nf, cr[7:0]};
    endfunction

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rdc(`ADR_FLAGS, 32'h0, "flags rst"); // reset value
        rdc(`ADR_SP, 32'hFF, "sp rst"); // reset value
        rdc(`ADR_STATE, 32'h0, "state rst"); // reset value
        rdc(12'h0F0, 32'h0, "unmapped"); // unmapped read
        $display("reset values done");
    endtask
    task automatic t_pm();
        wr(win(12'h400, 8'hFF), 32'hC3);
        wr(win(12'h400, 8'h00), 32'h3C);
        wr(win(12'h100, 8'd30), 32'hFF);
        wr(win(12'h100, 8'd31), 32'h12);
        wr(`ADR_FLAGS, 32'hA5);
        run_op(`OP_PML_INC, 14'd9);
        rdc(win(12'h100, 8'd9), 32'hC3, "pm byte");
        rdc(win(12'h100, 8'd30), 32'h00, "z low");
        rdc(win(12'h100, 8'd31), 32'h13, "z high");
        run_op(`OP_PML, 14'd10);
        rdc(win(12'h100, 8'd10), 32'h3C, "pm plain");
        rdc(`ADR_FLAGS, 32'hA5, "pm flags");
        $display("program load done");
    endtask
    task automatic t_stack();
        wr(win(12'h100, 8'd3), 32'h5A);
        wr(`ADR_FLAGS, 32'h3C);
        run_op(`OP_PUSH, 14'd3);
        rdc(`ADR_SP, 32'hFE, "sp push");
        wr(win(12'h100, 8'd3), 32'h00);
        run_op(`OP_POP, 14'd4);
        rdc(win(12'h100, 8'd4), 32'h5A, "pop val");
        rdc(`ADR_SP, 32'hFF, "sp pop");
        rdc(`ADR_FLAGS, 32'h3C, "stack flags");
        $display("stack done");
    endtask
    task automatic t_io();
        int b;
        wr(win(12'h200, 8'h3F), 32'h00);
        wr(`ADR_FLAGS, 32'h81);
        for (b = 0; b < 8; b++) begin
            run_op(`OP_IOSET, {6'h3F, b[2:0], 5'h0});
            rdc(win(12'h200, 8'h3F), (32'h2 << b) - 1, "io set");
        end
        for (b = 0; b < 8; b++) begin
            run_op(`OP_IOCLR, {6'h3F, b[2:0], 5'h0});
            rdc(win(12'h200, 8'h3F), 32'hFE << b & 32'hFF, "io clr");
        end
        run_op(`OP_OUT, {6'h05, 8'd4});
        run_op(`OP_IN, {6'h05, 8'd3});
        rdc(win(12'h100, 8'd3), 32'h5A, "in out"); // port copy
        rdc(`ADR_FLAGS, 32'h81, "io flags");
        $display("io bits done");
    endtask
    task automatic t_shift();
        logic [7:0] vals [4];
        logic [15:0] e;
        int op;
        int i;
        int c;
        vals = '{8'h81, 8'h80, 8'h01, 8'h96};
        for (op = `OP_LSL; op <= `OP_SWAP; op++)
            for (i = 0; i < 8; i++) begin
                c = i % 2;
                e = shift_ref(op[4:0], vals[i / 2], 8'h70 | c[7:0]);
                wr(win(12'h100, 8'd17), {24'h0, vals[i / 2]});
                wr(`ADR_FLAGS, 32'h70 | c);
                run_op(op[4:0], 14'd17);
                rdc(win(12'h100, 8'd17), e[7:0], "shift");
                rdc(`ADR_FLAGS, e[15:8], "shf flags");
            end
        $display("shifts done");
    endtask
    task automatic t_flags();
        int s;
        for (s = 0; s < 8; s++) begin
            wr(`ADR_FLAGS, 32'h00);
            run_op(`OP_FSET, {6'h0, s[2:0], 5'h0});
            rdc(`ADR_FLAGS, 32'h1 << s, "fset");
            wr(`ADR_FLAGS, 32'hFF);
            run_op(`OP_FCLR, {6'h0, s[2:0], 5'h0});
            rdc(`ADR_FLAGS, ~(32'h1 << s) & 32'hFF, "fclr");
        end
        wr(win(12'h100, 8'd7), 32'h08);
        wr(`ADR_FLAGS, 32'hBF);
        run_op(`OP_TSTORE, {6'h0, 3'd3, 5'd7});
        rdc(`ADR_FLAGS, 32'hFF, "t store 1");
        run_op(`OP_TSTORE, {6'h0, 3'd2, 5'd7});
        rdc(`ADR_FLAGS, 32'hBF, "t store 0");
        wr(`ADR_FLAGS, 32'h40);
        wr(win(12'h100, 8'd8), 32'h00);
        run_op(`OP_TLOAD, {6'h0, 3'd6, 5'd8});
        rdc(win(12'h100, 8'd8), 32'h40, "t load");
        rdc(`ADR_FLAGS, 32'h40, "tld flags");
        $display("flag ops done");
    endtask
    task automatic t_ctrl();
        logic [4:0] ops [4];
        int i;
        int k;
        ops = '{`OP_SLEEP, `OP_WDOG, `OP_BREAK, `OP_NOP};
        wr(`ADR_FLAGS, 32'h5A);
        for (i = 0; i < 4; i++) begin
            pulse_n = '{0, 0, 0};
            run_op(ops[i], 14'h0);
            for (k = 0; k < 3; k++)
                check(pulse_n[k], k == i, "pulse");
            rdc(`ADR_FLAGS, 32'h5A, "ctl flags");
        end
        $display("control ops done");
    endtask
    task automatic t_refuse();
        logic [31:0] r;
        wr(`ADR_FLAGS, 32'h11);
        wr(`ADR_CMD, {27'h0, `OP_PML});
        wr(`ADR_FLAGS, 32'hEE);
        run_op(`OP_NOP, 14'h0);
        rdc(`ADR_FLAGS, 32'h11, "busy write");
        xfer(1'b1, `ADR_FLAGS, 32'hEE, 4'hE, r);
        rdc(`ADR_FLAGS, 32'h11, "lane write");
        $display("refusals done");
    endtask

    initial begin
        reset_n = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 12'h000;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_pm();
        t_stack();
        t_io();
        t_shift();
        t_flags();
        t_ctrl();
        t_refuse();
        tally_and_finish();
    end
endmodule
